// [hdl/host_port_pkg.sv]
// constants and carrier types of the host byte port
package host_port_pkg;
    // control word bit positions
    localparam int CTL_CMD_FLAG    = 8;
    localparam int CTL_RSVD9       = 9;
    localparam int CTL_IV_IRQ_EN   = 10;
    localparam int CTL_MASTER_RST  = 11;
    localparam int CTL_FS_IRQ_EN   = 12;
    localparam int CTL_WR_IRQ_EN   = 13;
    localparam int CTL_RSVD14      = 14;
    localparam int CTL_GLOBAL_EN   = 15;
    localparam int CTL_LAST_DATA   = 7;
    // status word bit positions
    localparam int STS_KIND        = 8;
    localparam int STS_RESTART     = 9;
    localparam int STS_INPUT_VALID = 10;
    localparam int STS_RESET_PROG  = 11;
    localparam int STS_FIFO_SPACE  = 12;
    localparam int STS_WRITE_READY = 13;
    localparam int STS_POLL        = 14;
    localparam int STS_SUMMARY     = 15;
    // reset values and counts
    localparam logic [15:0] CTL_RESET      = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [2:0]  CMD_BLOCK_LEN  = 3'h5;
    localparam logic [2:0]  REPORT_LEN     = 3'h6;
    localparam int          FIFO_DEPTH     = 32;
    // one byte from the host on its way to the microprocessor
    typedef struct packed {
        logic       cmd;          // byte belongs to a command block
        logic       block_start;  // first byte of a command block
        logic [7:0] data;
    } host_byte_type;
    // one byte from the microprocessor for the host
    typedef struct packed {
        logic       kind;         // completion status, not data
        logic       restart;      // receive restart report
        logic [7:0] data;
    } fw_byte_type;
endpackage : host_port_pkg

// [hdl/byte_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap by power-of-two arithmetic only
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("byte_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // honest flags from the extra wrap bit
    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                   (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign push = ce_i && in_valid_i && !full;
    assign pop  = ce_i && out_ready_i && !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    // storage has no reset, only the pointers do
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // pointer update
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : byte_fifo

// [hdl/host_port_interrupt_handshake.sv]
// host byte port: control/status words, byte handshake, interrupt
`timescale 1ns/1ps
module host_port_interrupt_handshake #(
    parameter int FIFO_DEPTH = host_port_pkg::FIFO_DEPTH
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    // bit-addressable host bus
    input  wire logic                        bit_wr_i,
    input  wire logic [3:0]                  bit_addr_i,
    input  wire logic                        bit_wdata_i,
    output logic                             bit_rdata_o,
    output logic [15:0]                      status_word_o,
    output logic                             host_irq_o,
    // microprocessor side: bytes from the host
    output logic                             fw_rx_valid_o,
    input  wire logic                        fw_rx_ready_i,
    output host_port_pkg::host_byte_type     fw_rx_byte_o,
    // microprocessor side: bytes for the host
    input  wire logic                        fw_load_i,
    input  wire host_port_pkg::fw_byte_type  fw_tx_byte_i,
    input  wire logic                        fw_restart_clear_i,
    output logic                             fw_host_busy_o,
    input  wire logic                        fw_fifo_space_i,
    output logic                             fw_master_reset_o,
    input  wire logic                        fw_reset_done_i,
    input  wire logic                        fw_selftest_pass_i
);
    logic [15:0] control;
    logic [15:0] status;
    logic        write_ready;
    logic        input_valid_flag;
    logic        status_kind_flag;
    logic        restart_flag;
    logic        reset_in_progress_flag;
    logic        fifo_space_flag;
    logic        interrupt_pending_summary;
    logic        poll_flag;
    logic        poll_prev;
    logic [7:0]  host_data;
    logic [2:0]  report_left;
    logic [2:0]  block_left;
    logic        hold_valid;
    logic        hold_ready;
    logic        wr_en;
    logic        take;
    logic        byte_write;
    host_port_pkg::host_byte_type hold_byte;

    // a single-bit write strobe, gated by the clock enable
    function automatic logic hit(input logic [3:0] a, input int pos);
        return bit_wr_i && ce_i && (a == 4'(pos));
    endfunction : hit

    assign wr_en      = bit_wr_i && ce_i;
    assign byte_write = hit(bit_addr_i, host_port_pkg::CTL_LAST_DATA);
    assign take       = ce_i && hold_valid && hold_ready;

    // control word, written bit by bit; reserved bits held at zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            control <= host_port_pkg::CTL_RESET;
        end else if (wr_en) begin
            control[bit_addr_i] <= bit_wdata_i;
            if (bit_addr_i == 4'(host_port_pkg::CTL_RSVD14) ||
                bit_addr_i == 4'(host_port_pkg::CTL_RSVD9)) begin
                control[bit_addr_i] <= 1'b0;
            end
        end
    end

    // writing bit 7 closes the data byte and hands it over
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hold_valid <= 1'b0;
            hold_byte  <= '0;
            block_left <= '0;
        end else if (byte_write) begin
            hold_valid          <= 1'b1;
            hold_byte.data      <= {bit_wdata_i, control[6:0]};
            hold_byte.cmd       <= control[host_port_pkg::CTL_CMD_FLAG] ||
                                   (block_left != 3'h0);
            hold_byte.block_start <= control[host_port_pkg::CTL_CMD_FLAG];
            // a flagged byte opens a block; the rest need no flag
            if (control[host_port_pkg::CTL_CMD_FLAG]) begin
                block_left <= host_port_pkg::CMD_BLOCK_LEN - 3'h1;
            end else if (block_left != 3'h0) begin
                block_left <= block_left - 3'h1;
            end
        end else if (take) begin
            hold_valid <= 1'b0;
        end
    end

    // write-ready: cleared by the host byte, set once the byte is taken
    // a new byte in the same cycle as a take keeps it clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            write_ready <= 1'b0;
        end else if (ce_i) begin
            if (byte_write) begin
                write_ready <= 1'b0;
            end else if (take) begin
                write_ready <= 1'b1;
            end else if (fw_reset_done_i && fw_selftest_pass_i) begin
                write_ready <= !hold_valid;
            end
        end
    end

    // no gating on fifo space: commands still flow while it is full
    byte_fifo #(
        .WIDTH ($bits(host_port_pkg::host_byte_type)),
        .DEPTH (FIFO_DEPTH)
    ) rx_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (hold_valid),
        .in_ready_o  (hold_ready),
        .in_data_i   (hold_byte),
        .out_valid_o (fw_rx_valid_o),
        .out_ready_i (fw_rx_ready_i),
        .out_data_o  (fw_rx_byte_o)
    );

    // input-valid: a load sets it; any write to its enable clears it, except in a cycle with a load, which wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            input_valid_flag <= 1'b0;
        end else if (fw_load_i && ce_i) begin
            input_valid_flag <= 1'b1;
        end else if (hit(bit_addr_i, host_port_pkg::CTL_IV_IRQ_EN)) begin
            input_valid_flag <= 1'b0;
        end
    end

    // low byte and status-kind; only the first report byte is marked
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            host_data        <= host_port_pkg::BYTE_RESET;
            status_kind_flag <= 1'b0;
            report_left      <= '0;
        end else if (fw_load_i && ce_i) begin
            host_data <= fw_tx_byte_i.data;
            if (report_left != 3'h0) begin
                status_kind_flag <= 1'b0;
                report_left      <= report_left - 3'h1;
            end else begin
                status_kind_flag <= fw_tx_byte_i.kind;
                if (fw_tx_byte_i.kind && !fw_tx_byte_i.restart) begin
                    report_left <= host_port_pkg::REPORT_LEN - 3'h1;
                end
            end
        end
    end

    // restart report sets its bit; clearing waits for input-valid low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            restart_flag <= 1'b0;
        end else if (ce_i) begin
            if (fw_load_i && fw_tx_byte_i.restart) begin
                restart_flag <= 1'b1;
            end else if (fw_restart_clear_i && !input_valid_flag) begin
                restart_flag <= 1'b0;
            end
        end
    end

    // reset in progress: set at power-up and by the host request
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reset_in_progress_flag <= 1'b1;
            fw_master_reset_o      <= 1'b0;
        end else if (ce_i) begin
            fw_master_reset_o <= 1'b0;
            if (hit(bit_addr_i, host_port_pkg::CTL_MASTER_RST) &&
                bit_wdata_i) begin
                reset_in_progress_flag <= 1'b1;
                fw_master_reset_o      <= 1'b1;
            end else if (fw_reset_done_i && fw_selftest_pass_i) begin
                reset_in_progress_flag <= 1'b0;
            end
        end
    end

    // fifo space comes from firmware on the same clock
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fifo_space_flag <= 1'b0;
        end else if (ce_i) begin
            fifo_space_flag <= fw_fifo_space_i;
        end
    end

    // poll flag from the three enable/condition pairs
    assign poll_flag =
        (control[host_port_pkg::CTL_WR_IRQ_EN] && write_ready) ||
        (control[host_port_pkg::CTL_FS_IRQ_EN] && write_ready &&
         fifo_space_flag) ||
        (control[host_port_pkg::CTL_IV_IRQ_EN] && input_valid_flag);

    // summary is a registered level; a poll edge is caught with it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            interrupt_pending_summary <= 1'b0;
            poll_prev                 <= 1'b0;
        end else if (ce_i) begin
            poll_prev <= poll_flag;
            interrupt_pending_summary <=
                control[host_port_pkg::CTL_GLOBAL_EN] && poll_flag;
        end
    end

    assign host_irq_o = interrupt_pending_summary;

    // assembled status word
    always_comb begin
        status = {interrupt_pending_summary, poll_flag, write_ready,
                  fifo_space_flag, reset_in_progress_flag,
                  input_valid_flag, restart_flag, status_kind_flag,
                  host_data};
    end

    // read data are registered so the host sees a stable word
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_word_o <= '0;
            bit_rdata_o   <= 1'b0;
        end else if (ce_i) begin
            status_word_o <= status;
            bit_rdata_o   <= status[bit_addr_i];
        end
    end

    assign fw_host_busy_o = input_valid_flag;

    a_rst_ctl14: assert property (@(posedge sys_clk_i)
        rst_i |=> control[host_port_pkg::CTL_RSVD14] == 1'b0)
        else $error("reserved control bit not cleared");
    a_irq_needs_all: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) host_irq_o |->
        $past(control[host_port_pkg::CTL_GLOBAL_EN]) && $past(poll_flag))
        else $error("interrupt without enable and condition");
    a_poll_to_irq: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && poll_flag && !poll_prev &&
        control[host_port_pkg::CTL_GLOBAL_EN] |=> host_irq_o &&
        status[host_port_pkg::STS_SUMMARY])
        else $error("rising poll flag did not interrupt");
    a_wr_ready_irq: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && write_ready &&
        control[host_port_pkg::CTL_WR_IRQ_EN] &&
        control[host_port_pkg::CTL_GLOBAL_EN] |=> host_irq_o)
        else $error("write-ready did not interrupt");
    a_iv_irq: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && input_valid_flag &&
        control[host_port_pkg::CTL_IV_IRQ_EN] &&
        control[host_port_pkg::CTL_GLOBAL_EN] |=> host_irq_o)
        else $error("input-valid did not interrupt");
    a_load_sets_iv: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && fw_load_i |=> input_valid_flag)
        else $error("load did not set input-valid");
    a_iv_write_clr: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) hit(bit_addr_i, host_port_pkg::CTL_IV_IRQ_EN)
        && !fw_load_i |=> !input_valid_flag)
        else $error("enable write did not clear input-valid");
    a_restart_hold: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) restart_flag && input_valid_flag |=>
        restart_flag)
        else $error("restart cleared while input-valid set");
    a_restart_set: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && fw_load_i && fw_tx_byte_i.restart &&
        fw_tx_byte_i.kind && report_left == 3'h0 |=> restart_flag &&
        status_kind_flag && input_valid_flag)
        else $error("restart report incomplete");
    a_byte_clr_wr: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) byte_write |=> !write_ready && hold_valid)
        else $error("data byte write did not clear write-ready");
    a_rip_fail: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) reset_in_progress_flag &&
        !fw_selftest_pass_i |=> reset_in_progress_flag)
        else $error("reset-in-progress cleared on failed self-test");
    a_space_flag: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i |=>
        fifo_space_flag == $past(fw_fifo_space_i))
        else $error("fifo-space bit does not follow fifo");
    a_report_kind: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && fw_load_i && report_left != 3'h0
        |=> !status_kind_flag)
        else $error("status-kind set inside a report");
endmodule : host_port_interrupt_handshake

// [test/host_model.sv]
// host processor model driving the single-bit host bus
`timescale 1ns/1ps
module host_model (
    input  wire logic       sys_clk_i,
    output logic            bit_wr_o,
    output logic [3:0]      bit_addr_o,
    output logic            bit_wdata_o,
    input  wire logic       bit_rdata_i
);
    initial begin
        bit_wr_o    = 1'b0;
        bit_addr_o  = 4'h0;
        bit_wdata_o = 1'b0;
    end

    // one control bit per access, strobe held across one edge
    task automatic write_bit(input logic [3:0] a, input logic v);
        @(posedge sys_clk_i);
        bit_wr_o    <= 1'b1;
        bit_addr_o  <= a;
        bit_wdata_o <= v;
        @(posedge sys_clk_i);
        bit_wr_o    <= 1'b0;
        bit_wdata_o <= ~v; // a released line must not keep the old value
    endtask : write_bit

    // status bits are tested one at a time; rdata is registered
    task automatic read_bit(input logic [3:0] a, output logic v);
        @(posedge sys_clk_i);
        bit_addr_o <= a;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        #1 v = bit_rdata_i;
    endtask : read_bit

    // a byte goes out only once write-ready is seen; if it never comes
    // the write-ready interrupt is armed so the host can wait on it
    task automatic send_byte(input logic [7:0] d, input logic cmd,
                             output logic ok);
        logic r;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            read_bit(4'(host_port_pkg::STS_WRITE_READY), r);
            ok = (r === 1'b1);
        end
        if (!ok) begin
            write_bit(4'(host_port_pkg::CTL_WR_IRQ_EN), 1'b1);
        end else begin
            write_bit(4'(host_port_pkg::CTL_CMD_FLAG), cmd);
            for (int k = 0; k < 7; k++)
                write_bit(4'(k), d[k]);
            write_bit(4'(host_port_pkg::CTL_LAST_DATA), d[7]);
        end
    endtask : send_byte
endmodule : host_model

// [test/tb_top.sv]
// testbench of the host byte port
`timescale 1ns/1ps
module tb_top;
    logic                         sys_clk = 1'b0;
    logic                         rst;
    logic                         ce;
    logic                         bit_wr;
    logic [3:0]                   bit_addr;
    logic                         bit_wdata;
    logic                         bit_rdata;
    logic [15:0]                  status_word;
    logic                         host_irq;
    logic                         rx_valid;
    logic                         rx_ready;
    host_port_pkg::host_byte_type rx_byte;
    logic                         fw_load;
    host_port_pkg::fw_byte_type   tx_byte;
    logic                         restart_clr;
    logic                         host_busy;
    logic                         fifo_space;
    logic                         mreset;
    logic                         reset_done;
    logic                         st_pass;
    logic                         ok;
    int                           mismatches;
    int                           tests_run;
    int                           mreset_seen = 0;

    always #2.5 sys_clk = ~sys_clk;

    // small fifo so that filling it takes few bytes
    host_port_interrupt_handshake #(.FIFO_DEPTH(4)) dut_u (
        .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce),
        .bit_wr_i(bit_wr), .bit_addr_i(bit_addr), .bit_wdata_i(bit_wdata),
        .bit_rdata_o(bit_rdata), .status_word_o(status_word),
        .host_irq_o(host_irq), .fw_rx_valid_o(rx_valid),
        .fw_rx_ready_i(rx_ready), .fw_rx_byte_o(rx_byte),
        .fw_load_i(fw_load), .fw_tx_byte_i(tx_byte),
        .fw_restart_clear_i(restart_clr), .fw_host_busy_o(host_busy),
        .fw_fifo_space_i(fifo_space), .fw_master_reset_o(mreset),
        .fw_reset_done_i(reset_done), .fw_selftest_pass_i(st_pass));

    host_model host_u (
        .sys_clk_i(sys_clk), .bit_wr_o(bit_wr), .bit_addr_o(bit_addr),
        .bit_wdata_o(bit_wdata), .bit_rdata_i(bit_rdata));

    // reset request pulses seen by the firmware side
    always @(posedge sys_clk)
        if (mreset === 1'b1) mreset_seen++;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic check_bit(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : check_bit

    task automatic check_word(input string n, input logic [15:0] e,
                              input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check_word

    task automatic wr(input int a, input logic v);
        host_u.write_bit(4'(a), v);
    endtask : wr

    task automatic rd(input int a, input logic e, input string n);
        logic v;
        host_u.read_bit(4'(a), v);
        check_bit(n, e, v);
    endtask : rd

    // bounded wait on rx valid (0) or the host interrupt (1)
    task automatic await(input string n, input int which);
        for (int i = 0; i < 200; i++) begin
            if ((which == 0 ? rx_valid : host_irq) === 1'b1) return;
            @(posedge sys_clk);
            #1;
        end
        mismatches++;
        $display("[FAIL] %s expected 1 seen timeout", n);
        complete_run();
    endtask : await

    task automatic pulse_done(input logic p);
        @(posedge sys_clk);
        reset_done <= 1'b1;
        st_pass    <= p;
        @(posedge sys_clk);
        reset_done <= 1'b0;
        st_pass    <= ~p;
    endtask : pulse_done

    task automatic fw_byte(input logic k, input logic r, input logic [7:0] d);
        @(posedge sys_clk);
        fw_load <= 1'b1;
        tx_byte <= {k, r, d};
        @(posedge sys_clk);
        fw_load <= 1'b0;
        tx_byte <= ~{k, r, d};
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : fw_byte

    // microprocessor takes one byte, stalling until it shows
    task automatic pop(input logic c, input logic s, input logic [7:0] d);
        await("rx_valid", 0);
        check_word("rx_byte", {6'h00, c, s, d}, {6'h00, rx_byte});
        @(posedge sys_clk);
        rx_ready <= 1'b1;
        @(posedge sys_clk);
        rx_ready <= 1'b0;
        #1;
    endtask : pop

    initial begin
        ce = 1'b1; rst = 1'b1; rx_ready = 1'b0; fw_load = 1'b0;
        tx_byte = '0; restart_clr = 1'b0; fifo_space = 1'b1;
        reset_done = 1'b0; st_pass = 1'b0;
        mismatches = 0; tests_run = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        // power-up: reset in progress, write-ready held off
        rd(host_port_pkg::STS_RESET_PROG, 1'b1, "reset_busy");
        rd(host_port_pkg::STS_WRITE_READY, 1'b0, "wr_ready");
        pulse_done(1'b0);
        rd(host_port_pkg::STS_RESET_PROG, 1'b1, "selftest_fail");
        pulse_done(1'b1);
        rd(host_port_pkg::STS_RESET_PROG, 1'b0, "reset_done");
        rd(host_port_pkg::STS_WRITE_READY, 1'b1, "wr_ready");
        // fifo-space flag and its interrupt term
        @(posedge sys_clk) fifo_space <= 1'b0;
        rd(host_port_pkg::STS_FIFO_SPACE, 1'b0, "fifo_space");
        wr(host_port_pkg::CTL_FS_IRQ_EN, 1'b1);
        wr(host_port_pkg::CTL_GLOBAL_EN, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 check_bit("irq_no_cond", 1'b0, host_irq);
        @(posedge sys_clk) fifo_space <= 1'b1;
        await("irq_fifo_space", 1);
        rd(host_port_pkg::STS_POLL, 1'b1, "poll");
        rd(host_port_pkg::STS_SUMMARY, 1'b1, "summary");
        wr(host_port_pkg::CTL_FS_IRQ_EN, 1'b0);
        repeat (3) @(posedge sys_clk);
        #1 check_bit("irq_drop", 1'b0, host_irq);
        // command block while the transmit fifo is full, rx side stalled
        @(posedge sys_clk) fifo_space <= 1'b0;
        for (int b = 0; b < 5; b++) begin
            host_u.send_byte(8'(8'h30 + b), b == 0, ok);
            check_bit("byte_taken", 1'b1, ok);
        end
        rd(host_port_pkg::STS_WRITE_READY, 1'b0, "wr_ready_full");
        host_u.send_byte(8'h3f, 1'b0, ok);
        check_bit("byte_refused", 1'b0, ok);
        repeat (2) @(posedge sys_clk);
        #1 check_bit("irq_armed", 1'b0, host_irq);
        for (int b = 0; b < 5; b++)
            pop(1'b1, b == 0, 8'(8'h30 + b));
        check_bit("drained", 1'b0, rx_valid);
        await("irq_wr_ready", 1);
        wr(host_port_pkg::CTL_WR_IRQ_EN, 1'b0);
        @(posedge sys_clk) fifo_space <= 1'b1;
        // data waits until space is reported again
        rd(host_port_pkg::STS_FIFO_SPACE, 1'b1, "space_back");
        host_u.send_byte(8'h3f, 1'b0, ok);
        check_bit("byte_sent", 1'b1, ok);
        pop(1'b0, 1'b0, 8'h3f);
        // bytes for the host: plain data first
        wr(host_port_pkg::CTL_IV_IRQ_EN, 1'b1);
        fw_byte(1'b0, 1'b0, 8'ha5);
        check_word("data_load", 16'h04a5, status_word & 16'h07ff);
        check_bit("host_busy", 1'b1, host_busy);
        await("irq_input_valid", 1);
        wr(host_port_pkg::CTL_IV_IRQ_EN, 1'b0);
        rd(host_port_pkg::STS_INPUT_VALID, 1'b0, "iv_clear");
        check_bit("busy_idle", 1'b0, host_busy);
        check_bit("irq_idle", 1'b0, host_irq);
        // clock enable low: a load must leave no trace
        @(posedge sys_clk) ce <= 1'b0;
        fw_byte(1'b0, 1'b0, 8'h5a);
        @(posedge sys_clk) ce <= 1'b1;
        rd(host_port_pkg::STS_INPUT_VALID, 1'b0, "ce_freeze");
        check_word("ce_byte", 16'h00a5, status_word & 16'h07ff);
        // restart report: clear request ignored until host acknowledges
        fw_byte(1'b1, 1'b1, 8'h11);
        check_word("restart", 16'h0711, status_word & 16'h07ff);
        @(posedge sys_clk) restart_clr <= 1'b1;
        @(posedge sys_clk) restart_clr <= 1'b0;
        rd(host_port_pkg::STS_RESTART, 1'b1, "restart_held");
        // host restarts its receive request and acknowledges the report
        wr(host_port_pkg::CTL_IV_IRQ_EN, 1'b0);
        @(posedge sys_clk) restart_clr <= 1'b1;
        @(posedge sys_clk) restart_clr <= 1'b0;
        rd(host_port_pkg::STS_RESTART, 1'b0, "restart_clear");
        // six-byte completion report, then the next report opens
        for (int n = 0; n < 7; n++) begin
            fw_byte(1'b1, 1'b0, 8'(8'h50 + n));
            check_word("report", {5'h00, 2'b10, n == 0 || n == 6,
                       8'(8'h50 + n)}, status_word & 16'h07ff);
            wr(host_port_pkg::CTL_IV_IRQ_EN, 1'b0);
        end
        // host-requested master reset
        wr(host_port_pkg::CTL_MASTER_RST, 1'b1);
        rd(host_port_pkg::STS_RESET_PROG, 1'b1, "host_reset");
        check_word("reset_pulses", 16'h0001, 16'(mreset_seen));
        wr(host_port_pkg::CTL_MASTER_RST, 1'b0);
        pulse_done(1'b1);
        rd(host_port_pkg::STS_RESET_PROG, 1'b0, "reset_end");
        complete_run();
    end
endmodule : tb_top
